/* File: hdl/disk_result_code_encoder.sv */
// Purpose: Builds the one-byte result code returned after each disk command.
// Assumes: Outcome requests come from logic on ref_clk (200 MHz); no pin inputs.
// Notes:   Result is valid two cycles after the request and holds until the next.
`timescale 1ns/1ps
module disk_result_code_encoder (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        req,
  input  wire result_code_pkg::outcome_type outcome,
  output logic                             valid,
  output logic [7:0]                       result,
  output logic [4:0]                       error_field,
  output logic                             field_meaningful,
  output logic                             code_illegal
);

  result_code_pkg::source_type  held_source;
  logic [4:0]                   held_field;
  logic [7:0]                   legacy_code;
  logic [7:0]                   fixed_code;
  logic                         req_d;
  logic                         field_bad;

  // The formers register the outcome at the taking edge themselves, so only the
  // source and the field are kept here; a second capture stage in front of the
  // formers would push the answer out to three cycles.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_field  <= '0;
      held_source <= result_code_pkg::SRC_LEGACY;
    end else if (req) begin
      held_field  <= outcome.legacy.code;
      held_source <= outcome.source;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_d <= 1'b0;
    end else begin
      req_d <= req;
    end
  end

  // Field values above the last defined cause have no meaning.
  assign field_bad = (held_field > result_code_pkg::ERR_LAST);

  legacy_code_former u_legacy (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .event_in (outcome.legacy),
    .code     (legacy_code)
  );

  fixed_code_table u_fixed (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .source  (outcome.source),
    .newer   (outcome.newer),
    .user    (outcome.user),
    .code    (fixed_code)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
    end else begin
      valid <= req_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= result_code_pkg::RESULT_RESET;
    end else if (req_d) begin
      if (held_source == result_code_pkg::SRC_LEGACY) begin
        result <= legacy_code;
      end else begin
        result <= fixed_code;
      end
    end
  end

  // Decode side helpers mirror what the host does with an older-family byte.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_field      <= '0;
      field_meaningful <= 1'b0;
    end else if (req_d) begin
      error_field      <= legacy_code[result_code_pkg::FIELD_MSB:0];
      field_meaningful <= (held_source == result_code_pkg::SRC_LEGACY)
                          && |(legacy_code & result_code_pkg::FLAG_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_illegal <= 1'b0;
    end else if (req_d) begin
      // A result being delivered wins over the clear of a following request.
      code_illegal <= (held_source == result_code_pkg::SRC_LEGACY) && field_bad;
    end else if (req) begin
      code_illegal <= 1'b0;
    end
  end

endmodule : disk_result_code_encoder

/* File: pkg/result_code_pkg.sv */
// Purpose: Shared constants and types for the disk result code encoder.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Result byte layout, error field values and fixed code sets.
package result_code_pkg;

  localparam int unsigned FIELD_MSB   = 4;
  localparam int unsigned RECOV_BIT   = 5;
  localparam int unsigned VERIFY_BIT  = 6;
  localparam int unsigned HARD_BIT    = 7;
  localparam logic [7:0]  RESULT_RESET = 8'h00;
  localparam logic [7:0]  FLAG_MASK    = 8'hE0;

  // Older family error field values.
  localparam logic [4:0] ERR_HEADER_FAULT    = 5'h00;
  localparam logic [4:0] ERR_SEEK_TIMEOUT    = 5'h01;
  localparam logic [4:0] ERR_SEEK_FAULT      = 5'h02;
  localparam logic [4:0] ERR_SEEK_ERROR      = 5'h03;
  localparam logic [4:0] ERR_HEADER_CRC      = 5'h04;
  localparam logic [4:0] ERR_REZERO_FAULT    = 5'h05;
  localparam logic [4:0] ERR_REZERO_TIMEOUT  = 5'h06;
  localparam logic [4:0] ERR_DRIVE_OFFLINE   = 5'h07;
  localparam logic [4:0] ERR_WRITE_FAULT     = 5'h08;
  localparam logic [4:0] ERR_UNUSED          = 5'h09;
  localparam logic [4:0] ERR_READ_DATA_FAULT = 5'h0A;
  localparam logic [4:0] ERR_DATA_CRC        = 5'h0B;
  localparam logic [4:0] ERR_SECTOR_LOCATE   = 5'h0C;
  localparam logic [4:0] ERR_WRITE_PROTECT   = 5'h0D;
  localparam logic [4:0] ERR_ILLEGAL_SECTOR  = 5'h0E;
  localparam logic [4:0] ERR_ILLEGAL_OPCODE  = 5'h0F;
  localparam logic [4:0] ERR_NOT_ACK         = 5'h10;
  localparam logic [4:0] ERR_ACK_STUCK       = 5'h11;
  localparam logic [4:0] ERR_TIMEOUT         = 5'h12;
  localparam logic [4:0] ERR_FAULT           = 5'h13;
  localparam logic [4:0] ERR_CRC             = 5'h14;
  localparam logic [4:0] ERR_SEEK            = 5'h15;
  localparam logic [4:0] ERR_VERIFICATION    = 5'h16;
  localparam logic [4:0] ERR_SPEED           = 5'h17;
  localparam logic [4:0] ERR_ILLEGAL_ADDRESS = 5'h18;
  localparam logic [4:0] ERR_RW_FAULT        = 5'h19;
  localparam logic [4:0] ERR_SERVO           = 5'h1A;
  localparam logic [4:0] ERR_GUARD_BAND      = 5'h1B;
  localparam logic [4:0] ERR_PLO             = 5'h1C;
  localparam logic [4:0] ERR_RW_UNSAFE       = 5'h1D;
  localparam logic [4:0] ERR_LAST            = 5'h1D;

  // Newer variant fixed codes.
  localparam logic [7:0] NEW_NO_ERROR        = 8'h00;
  localparam logic [7:0] NEW_SEEK_ERROR      = 8'h83;
  localparam logic [7:0] NEW_SOFT_HEADER     = 8'h24;
  localparam logic [7:0] NEW_HARD_HEADER     = 8'h84;
  localparam logic [7:0] NEW_NOT_READY       = 8'h87;
  localparam logic [7:0] NEW_SOFT_DATA_CRC   = 8'h2B;
  localparam logic [7:0] NEW_HARD_DATA_CRC   = 8'h8B;
  localparam logic [7:0] NEW_ILLEGAL_SECTOR  = 8'h8E;
  localparam logic [7:0] NEW_ILLEGAL_OPCODE  = 8'h8F;
  localparam logic [7:0] NEW_FORMAT_FW_FAIL  = 8'h9D;
  localparam logic [7:0] NEW_BOOT_READ_FAIL  = 8'h9F;

  // Active user table and boot command codes.
  localparam logic [7:0] USER_OK             = 8'h00;
  localparam logic [7:0] USER_NO_ROOM        = 8'h01;
  localparam logic [7:0] USER_DUPLICATE      = 8'h02;
  localparam logic [7:0] USER_NOT_FOUND      = 8'h03;
  localparam logic [7:0] BOOT_NOT_INIT       = 8'h04;

  typedef enum logic [1:0] {
    SRC_LEGACY,
    SRC_NEWER,
    SRC_USER,
    SRC_BOOT
  } source_type;

  typedef enum logic [3:0] {
    NEW_OK,
    NEW_SEEK,
    NEW_HDR_SOFT,
    NEW_HDR_HARD,
    NEW_NOTREADY,
    NEW_CRC_SOFT,
    NEW_CRC_HARD,
    NEW_BAD_SECTOR,
    NEW_BAD_OPCODE,
    NEW_FW_FORMAT,
    NEW_BOOT_READ
  } newer_event_type;

  typedef enum logic [1:0] {
    USR_OK,
    USR_NO_ROOM,
    USR_DUPLICATE,
    USR_NOT_FOUND
  } user_event_type;

  typedef struct packed {
    logic       success;
    logic       hard;
    logic       verify;
    logic       recover;
    logic [4:0] code;
  } legacy_event_type;

  typedef struct packed {
    source_type       source;
    legacy_event_type legacy;
    newer_event_type  newer;
    user_event_type   user;
  } outcome_type;

  typedef struct packed {
    logic       hard;
    logic       verify;
    logic       recover;
    logic [4:0] field;
  } result_byte_type;

endpackage : result_code_pkg

/* File: hdl/legacy_code_former.sv */
// Purpose: Forms the older family result byte from flags and an error field.
// Assumes: Inputs come from logic on ref_clk.
// Notes:   Registered output; one cycle latency.
`timescale 1ns/1ps
module legacy_code_former (
  input  wire logic                             ref_clk,
  input  wire logic                             rst_n,
  input  wire result_code_pkg::legacy_event_type event_in,
  output logic [7:0]                            code
);

  logic [7:0] next_code;
  logic       soft_only;

  // A soft outcome never carries the hard flag; only a hard request sets it.
  assign soft_only = !event_in.hard && (event_in.recover || event_in.verify);

  always_comb begin
    next_code = result_code_pkg::RESULT_RESET;
    if (event_in.success) begin
      next_code = result_code_pkg::RESULT_RESET;
    end else if (event_in.hard) begin
      next_code[result_code_pkg::HARD_BIT]   = 1'b1;
      next_code[result_code_pkg::RECOV_BIT]  = event_in.recover;
      next_code[result_code_pkg::VERIFY_BIT] = event_in.verify;
      next_code[result_code_pkg::FIELD_MSB:0] = event_in.code;
    end else if (soft_only) begin
      next_code[result_code_pkg::RECOV_BIT]  = event_in.recover;
      next_code[result_code_pkg::VERIFY_BIT] = event_in.verify;
      next_code[result_code_pkg::FIELD_MSB:0] = event_in.code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= result_code_pkg::RESULT_RESET;
    end else begin
      code <= next_code;
    end
  end

endmodule : legacy_code_former

/* File: hdl/fixed_code_table.sv */
// Purpose: Maps newer variant, user table and boot outcomes to fixed codes.
// Assumes: Inputs come from logic on ref_clk.
// Notes:   Registered output; one cycle latency.
`timescale 1ns/1ps
module fixed_code_table (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire result_code_pkg::source_type     source,
  input  wire result_code_pkg::newer_event_type newer,
  input  wire result_code_pkg::user_event_type user,
  output logic [7:0]                           code
);

  logic [7:0] newer_code;
  logic [7:0] user_code;
  logic [7:0] next_code;

  always_comb begin
    newer_code = result_code_pkg::NEW_ILLEGAL_OPCODE;
    unique case (newer)
      result_code_pkg::NEW_OK:         newer_code = result_code_pkg::NEW_NO_ERROR;
      result_code_pkg::NEW_SEEK:       newer_code = result_code_pkg::NEW_SEEK_ERROR;
      result_code_pkg::NEW_NOTREADY:   newer_code = result_code_pkg::NEW_NOT_READY;
      result_code_pkg::NEW_BAD_SECTOR: newer_code = result_code_pkg::NEW_ILLEGAL_SECTOR;
      result_code_pkg::NEW_BAD_OPCODE: newer_code = result_code_pkg::NEW_ILLEGAL_OPCODE;
      result_code_pkg::NEW_HDR_SOFT:   newer_code = result_code_pkg::NEW_SOFT_HEADER;
      result_code_pkg::NEW_HDR_HARD:   newer_code = result_code_pkg::NEW_HARD_HEADER;
      result_code_pkg::NEW_CRC_SOFT:   newer_code = result_code_pkg::NEW_SOFT_DATA_CRC;
      result_code_pkg::NEW_CRC_HARD:   newer_code = result_code_pkg::NEW_HARD_DATA_CRC;
      result_code_pkg::NEW_FW_FORMAT:  newer_code = result_code_pkg::NEW_FORMAT_FW_FAIL;
      result_code_pkg::NEW_BOOT_READ:  newer_code = result_code_pkg::NEW_BOOT_READ_FAIL;
      // Unassigned event codes report as an illegal opcode.
      default:                         newer_code = result_code_pkg::NEW_ILLEGAL_OPCODE;
    endcase
  end

  always_comb begin
    user_code = result_code_pkg::USER_OK;
    unique case (user)
      result_code_pkg::USR_OK:        user_code = result_code_pkg::USER_OK;
      result_code_pkg::USR_NO_ROOM:   user_code = result_code_pkg::USER_NO_ROOM;
      result_code_pkg::USR_DUPLICATE: user_code = result_code_pkg::USER_DUPLICATE;
      result_code_pkg::USR_NOT_FOUND: user_code = result_code_pkg::USER_NOT_FOUND;
    endcase
  end

  always_comb begin
    next_code = result_code_pkg::RESULT_RESET;
    unique case (source)
      result_code_pkg::SRC_NEWER:  next_code = newer_code;
      result_code_pkg::SRC_USER:   next_code = user_code;
      result_code_pkg::SRC_BOOT:   next_code = result_code_pkg::BOOT_NOT_INIT;
      result_code_pkg::SRC_LEGACY: next_code = result_code_pkg::RESULT_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= result_code_pkg::RESULT_RESET;
    end else begin
      code <= next_code;
    end
  end

endmodule : fixed_code_table

/* File: tb/disk_result_code_encoder_props.sv */
// Purpose: Port-level assertions for the disk result code encoder.
// Assumes: One ref_clk domain, rst_n asynchronous and active low.
// Notes:   Legacy, user and boot results are judged two cycles after their taking edge.
`timescale 1ns/1ps
module disk_result_code_encoder_props (
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic                         req,
  input wire result_code_pkg::outcome_type outcome,
  input wire logic                         valid,
  input wire logic [7:0]                   result,
  input wire logic [4:0]                   error_field,
  input wire logic                         field_meaningful,
  input wire logic                         code_illegal
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic leg;
  logic flags;
  assign leg   = req && outcome.source == result_code_pkg::SRC_LEGACY;
  assign flags = outcome.legacy.hard | outcome.legacy.verify | outcome.legacy.recover;

  a_answer_delay: assert property (req |-> ##2 valid)
    else $error("valid did not follow a request by two cycles");
  a_no_spare_valid: assert property (valid |-> $past(req, 2))
    else $error("valid without a request two cycles earlier");
  a_hard_flag_set: assert property (leg && !outcome.legacy.success && outcome.legacy.hard
    |-> ##2 result[7])
    else $error("hard error without bit 7");
  a_soft_flags_only: assert property (leg && !outcome.legacy.success && !outcome.legacy.hard
    |-> ##2 result[7:5] == {1'b0, $past(outcome.legacy.verify, 2),
    $past(outcome.legacy.recover, 2)})
    else $error("soft error flags wrong");
  a_field_or_code: assert property (leg && !outcome.legacy.success && flags
    |-> ##2 result[4:0] == $past(outcome.legacy.code, 2) && error_field == result[4:0])
    else $error("error field not carried in low bits");
  a_success_zero: assert property (leg && outcome.legacy.success |-> ##2 result == 8'h00)
    else $error("success did not return zero");
  a_trust_follows_flags: assert property (leg
    |-> ##2 field_meaningful == (result[7:5] != 3'h0))
    else $error("field trust flag disagrees with flag bits");
  a_user_codes: assert property (req && outcome.source == result_code_pkg::SRC_USER
    |-> ##2 result == {6'h00, $past(outcome.user, 2)})
    else $error("user table code wrong");
  a_boot_code: assert property (req && outcome.source == result_code_pkg::SRC_BOOT
    |-> ##2 result == 8'h04)
    else $error("boot code wrong");
  a_result_holds: assert property (!valid |-> $stable(result))
    else $error("result changed without valid");
  a_illegal_field: assert property (leg && outcome.legacy.code > 5'h1D |-> ##2 code_illegal)
    else $error("field beyond 1Dh not flagged");
endmodule : disk_result_code_encoder_props

/* File: tb/host_result_reader.sv */
// Purpose: Host side reader of the result byte.
// Assumes: Result is read only in the cycle where valid is high.
// Notes:   Pure decode; the host never stalls the encoder.
`timescale 1ns/1ps
module host_result_reader (
  input  wire logic       valid,
  input  wire logic [7:0] result,
  output logic            trusted,
  output logic [4:0]      field
);
  assign trusted = valid && (result[7:5] != 3'h0);
  assign field   = result[4:0] & 5'h1F;
endmodule : host_result_reader

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the disk result code encoder.
// Assumes: Inputs change on the falling edge; results checked on the falling edge.
// Notes:   Expected bytes are queued by the driver and popped on valid.
`timescale 1ns/1ps
module tb_top;
  logic                         ref_clk = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         req = 1'b0;
  result_code_pkg::outcome_type outcome = '0;
  result_code_pkg::outcome_type o;
  logic                         valid;
  logic [7:0]                   result;
  logic [4:0]                   error_field;
  logic                         field_meaningful;
  logic                         code_illegal;
  logic                         trusted;
  logic [4:0]                   field;
  logic [9:0]                   e;
  logic [9:0]                   expq[$];
  logic [7:0]                   newer_codes[11] = '{8'h00, 8'h83, 8'h24, 8'h84, 8'h87,
                                                    8'h2B, 8'h8B, 8'h8E, 8'h8F, 8'h9D, 8'h9F};
  int                           failures = 0;
  int                           checks_done = 0;
  int                           seed = 32'h34DF7568;
  logic [31:0]                  r;

  always #2.5 ref_clk = ~ref_clk;

  disk_result_code_encoder uut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .outcome(outcome),
    .valid(valid), .result(result), .error_field(error_field),
    .field_meaningful(field_meaningful), .code_illegal(code_illegal));
  host_result_reader host (.valid(valid), .result(result), .trusted(trusted), .field(field));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Back-to-back calls keep req high, so each cycle is a fresh request.
  task automatic send(input result_code_pkg::outcome_type oc, input logic [9:0] ex);
    @(negedge ref_clk);
    req = 1'b1;
    outcome = oc;
    expq.push_back(ex);
  endtask : send

  // Expected legacy byte: flags ORed onto the field, zero when no flag is up.
  function automatic logic [9:0] leg_exp(input logic [7:0] b);
    return {b[4:0] > 5'h1D, 1'b1, (b[7:5] != 3'h0) ? b : 8'h00};
  endfunction : leg_exp

  always @(negedge ref_clk) begin
    if (valid === 1'b1) begin
      if (expq.size() == 0) check("spare valid", 8'h01, 8'h00);
      else begin
        e = expq.pop_front();
        check("result", result, e[7:0]);
        if (e[8]) begin
          check("error field", {3'h0, error_field}, {3'h0, e[4:0]});
          check("host field", {3'h0, field}, {3'h0, e[4:0]});
          check("trusted", {7'h00, field_meaningful}, {7'h00, trusted});
          check("illegal", {7'h00, code_illegal}, {7'h00, e[9]});
        end
      end
    end
  end

  initial begin
    #20000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    o = '0;
    for (int c = 0; c < 32; c++) begin
      for (int f = 0; f < 8; f++) begin
        o.legacy = {1'b0, f[2:0], c[4:0]};
        send(o, leg_exp({f[2:0], c[4:0]}));
      end
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      o.legacy = {1'b1, r[7:0]};
      send(o, {r[4:0] > 5'h1D, 9'h100});
    end
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      o.legacy = {1'b0, r[7:0]};
      send(o, leg_exp(r[7:0]));
    end
    o.source = result_code_pkg::SRC_NEWER;
    // Event codes past the last named one must report as an illegal opcode.
    for (int i = 0; i < 16; i++) begin
      o.newer = result_code_pkg::newer_event_type'(i);
      send(o, {2'b00, (i < 11) ? newer_codes[i] : 8'h8F});
    end
    o.source = result_code_pkg::SRC_USER;
    for (int i = 0; i < 4; i++) begin
      o.user = result_code_pkg::user_event_type'(i);
      send(o, {8'h00, i[1:0]});
    end
    o.source = result_code_pkg::SRC_BOOT;
    send(o, 10'h004);
    @(negedge ref_clk);
    req = 1'b0;
    for (int i = 0; i < 10 && expq.size() != 0; i++) @(posedge ref_clk);
    if (expq.size() != 0) check("results outstanding", 8'h01, 8'h00);
    wrap_up();
  end
endmodule : tb_top

bind disk_result_code_encoder disk_result_code_encoder_props props (.ref_clk(ref_clk),
  .rst_n(rst_n), .req(req), .outcome(outcome), .valid(valid), .result(result),
  .error_field(error_field), .field_meaningful(field_meaningful), .code_illegal(code_illegal));
